/* dsrb_top.sv */
// Serial slave and register bank of the display supply
module dsrb_top
    import dsrb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic positive_rail_enable_pin,
    input wire logic negative_rail_enable_pin,
    input wire logic otp_event,
    input wire logic [2:0] undervoltage_flag,
    output logic boost_rail_on,
    output logic negative_pump_rail_on,
    output logic positive_ldo_rail_on,
    output logic positive_pulldown_off,
    output logic [4:0] boost_level_code,
    output logic [4:0] negative_level_code,
    output logic [4:0] positive_level_code,
    output logic [1:0] switch_node_slew,
    output logic boost_light_load_pulse_mode_off,
    output logic [2:0] boost_freq_sel,
    output logic pump_light_load_pulse_mode_off,
    output logic pump_min_pulse_short,
    output logic [1:0] pump_peak_current_sel,
    output logic [1:0] pump_pulse_len_sel
);
    typedef enum {
        DSRB_IDLE, DSRB_DEVADR, DSRB_ACK, DSRB_REGADR, DSRB_WDATA,
        DSRB_RDATA, DSRB_RACK, DSRB_WAIT
    } dsrb_state_t;

    // ------------------------------------------------------------
    // Synchronisers and edge detection
    // ------------------------------------------------------------
    dsrb_sync_if sy ();

    dsrb_sync u_sync
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .pos_in(positive_rail_enable_pin),
        .neg_in(negative_rail_enable_pin),
        .so(sy)
    );

    logic scl_d;
    logic sda_d;
    logic pins_low_seen;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= sy.scl;
            sda_d <= sy.sda;
        end
    end
    wire scl_rise = sy.scl & ~scl_d;
    wire scl_fall = ~sy.scl & scl_d;
    wire start_det = scl_d & sy.scl & sda_d & ~sy.sda;
    wire stop_det = scl_d & sy.scl & ~sda_d & sy.sda;

    // ------------------------------------------------------------
    // Serial protocol engine
    // ------------------------------------------------------------
    dsrb_state_t state;
    dsrb_state_t after_ack;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] pointer;
    logic [7:0] tx_byte;
    logic drive_low;
    logic rd_nack;

    wire byte_done = scl_rise & (bit_cnt == 4'h7);
    wire [7:0] rx_byte = {shreg[6:0], sy.sda};
    wire addr_hit = (rx_byte[7:1] == DSRB_DEV_ADDR);
    wire wr_strobe = (state == DSRB_WDATA) & byte_done & ~stop_det;
    // Load at the fall that ends the address ack, once per read
    wire rd_load = (state == DSRB_ACK) & scl_fall & drive_low &
                   (after_ack == DSRB_RDATA);
    wire rd_fault = rd_load & (pointer == DSRB_OFS_FAULT);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= DSRB_IDLE;
            after_ack <= DSRB_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            pointer <= 8'h00;
            drive_low <= 1'b0;
            rd_nack <= 1'b0;
        end
        else if (start_det)
        begin
            state <= DSRB_DEVADR;
            bit_cnt <= 4'h0;
            drive_low <= 1'b0;
        end
        else if (stop_det)
        begin
            state <= DSRB_IDLE;
            drive_low <= 1'b0;
        end
        else
        begin
            case (state)
                DSRB_IDLE, DSRB_WAIT:
                    drive_low <= 1'b0;
                DSRB_DEVADR, DSRB_REGADR, DSRB_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shreg <= rx_byte;
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (byte_done)
                    begin
                        if (state == DSRB_DEVADR && !addr_hit)
                            state <= DSRB_WAIT;
                        else
                        begin
                            state <= DSRB_ACK;
                            if (state == DSRB_DEVADR)
                                after_ack <= rx_byte[0] ? DSRB_RDATA
                                                        : DSRB_REGADR;
                            else
                                after_ack <= DSRB_WDATA;
                            if (state == DSRB_REGADR)
                                pointer <= rx_byte;
                        end
                    end
                end
                DSRB_ACK:
                begin
                    if (scl_fall && !drive_low)
                        drive_low <= 1'b1;
                    else if (scl_fall)
                    begin
                        drive_low <= 1'b0;
                        bit_cnt <= 4'h0;
                        state <= after_ack;
                        if (after_ack == DSRB_RDATA)
                            shreg <= tx_byte;
                    end
                end
                DSRB_RDATA:
                begin
                    if (scl_rise)
                        bit_cnt <= bit_cnt + 4'h1;
                    if (scl_fall)
                    begin
                        if (bit_cnt == 4'h8)
                            state <= DSRB_RACK;
                        else
                            shreg <= {shreg[6:0], 1'b0};
                    end
                end
                DSRB_RACK:
                begin
                    if (scl_rise)
                        rd_nack <= sy.sda;
                    if (scl_fall)
                    begin
                        bit_cnt <= 4'h0;
                        shreg <= tx_byte;
                        state <= rd_nack ? DSRB_WAIT : DSRB_RDATA;
                    end
                end
                default:
                    state <= DSRB_IDLE;
            endcase
        end
    end

    // Ack drives low, read data drives msb
    wire tx_low = (state == DSRB_RDATA) & ~shreg[7];
    assign sda_out = 1'b0;
    assign sda_oe_n = ~(drive_low | tx_low);

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    logic [7:0] rail_enable;
    logic [7:0] boost_level;
    logic [7:0] negative_level;
    logic [7:0] positive_level;
    logic [7:0] boost_control;
    logic [7:0] pump_control;
    logic [7:0] fault_status;
    logic otp_read_once;

    wire wr_en = wr_strobe & (pointer == DSRB_OFS_ENABLE);
    wire wr_bl = wr_strobe & (pointer == DSRB_OFS_BOOST_LVL);
    wire wr_nl = wr_strobe & (pointer == DSRB_OFS_NEG_LVL);
    wire wr_pl = wr_strobe & (pointer == DSRB_OFS_POS_LVL);
    wire wr_bc = wr_strobe & (pointer == DSRB_OFS_BOOST_CTL);
    wire wr_pc = wr_strobe & (pointer == DSRB_OFS_PUMP_CTL);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rail_enable <= DSRB_RST_ENABLE;
            boost_level <= DSRB_RST_LEVEL;
            negative_level <= DSRB_RST_LEVEL;
            positive_level <= DSRB_RST_LEVEL;
            boost_control <= DSRB_RST_BOOST_CTL;
            pump_control <= DSRB_RST_PUMP_CTL;
        end
        else
        begin
            if (wr_en)
                rail_enable <= rx_byte & DSRB_EN_WMASK;
            if (wr_bl)
                boost_level <= rx_byte;
            if (wr_nl)
                negative_level <= rx_byte;
            if (wr_pl)
                positive_level <= rx_byte;
            if (wr_bc)
                boost_control <= rx_byte;
            if (wr_pc)
                pump_control <= rx_byte;
        end
    end

    assign tx_byte =
        (pointer == DSRB_OFS_FAULT) ? fault_status :
        (pointer == DSRB_OFS_ENABLE) ? rail_enable :
        (pointer == DSRB_OFS_BOOST_LVL) ? boost_level :
        (pointer == DSRB_OFS_NEG_LVL) ? negative_level :
        (pointer == DSRB_OFS_POS_LVL) ? positive_level :
        (pointer == DSRB_OFS_BOOST_CTL) ? boost_control :
        (pointer == DSRB_OFS_PUMP_CTL) ? pump_control : 8'h00;

    // ------------------------------------------------------------
    // Fault latching and clearing
    // ------------------------------------------------------------
    wire pins_low = ~sy.pos_pin & ~sy.neg_pin;
    wire pins_high = sy.pos_pin & sy.neg_pin;
    wire pin_cycle = pins_low_seen & pins_high;
    wire otp_clear = rd_fault & otp_read_once & fault_status[0];
    wire [3:0] flt_set = {undervoltage_flag[2], undervoltage_flag[1],
                          undervoltage_flag[0], otp_event};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            fault_status <= DSRB_RST_FAULT;
            pins_low_seen <= 1'b0;
            otp_read_once <= 1'b0;
        end
        else
        begin
            if (pins_low)
                pins_low_seen <= 1'b1;
            else if (!pins_high && (sy.pos_pin | sy.neg_pin) && !pins_low_seen)
                pins_low_seen <= 1'b0;
            else if (pin_cycle)
                pins_low_seen <= 1'b0;
            if (pin_cycle)
                fault_status[3:0] <= flt_set;
            else if (otp_clear)
                fault_status[3:0] <= {fault_status[3:1] | flt_set[3:1],
                                      otp_event};
            else
                fault_status[3:0] <= fault_status[3:0] | flt_set;
            if (otp_clear || pin_cycle)
                otp_read_once <= 1'b0;
            else if (rd_fault && fault_status[DSRB_FLT_OTP_BIT])
                otp_read_once <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Regulator controls
    // ------------------------------------------------------------
    // bit and pin, boost from either pin; pull-down disable from bit alone
    assign boost_rail_on = rail_enable[DSRB_EN_BOOST_BIT] &
                           (sy.pos_pin | sy.neg_pin);
    assign negative_pump_rail_on = rail_enable[DSRB_EN_NEG_BIT] & sy.neg_pin;
    assign positive_ldo_rail_on = rail_enable[DSRB_EN_POS_BIT] & sy.pos_pin;
    assign positive_pulldown_off = rail_enable[DSRB_EN_PULLDN_DIS_BIT];
    assign boost_level_code = boost_level[DSRB_LEVEL_MSB:0];
    assign negative_level_code = negative_level[DSRB_LEVEL_MSB:0];
    assign positive_level_code = positive_level[DSRB_LEVEL_MSB:0];
    assign switch_node_slew = boost_control[DSRB_BC_SLEW_LSB+:2];
    assign boost_light_load_pulse_mode_off =
        boost_control[DSRB_BC_PFM_DIS_BIT];
    assign boost_freq_sel = boost_control[2:0];
    assign pump_light_load_pulse_mode_off = pump_control[DSRB_PC_PFM_DIS_BIT];
    assign pump_min_pulse_short = pump_control[DSRB_PC_MIN_PULSE_BIT];
    assign pump_peak_current_sel = pump_control[DSRB_PC_PEAK_LSB+:2];
    assign pump_pulse_len_sel = pump_control[DSRB_PC_PULSE_LSB+:2];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_write_lands;
        @(posedge sys_clk) disable iff (rst)
        wr_bl |=> boost_level == $past(rx_byte);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("level write not stored");

    property p_enable_reserved;
        @(posedge sys_clk) disable iff (rst)
        rail_enable[7] == 1'b0;
    endproperty
    a_enable_reserved: assert property (p_enable_reserved)
        else $error("enable bit 7 set");

    property p_reset_defaults;
        @(posedge sys_clk)
        rst |=> rail_enable == DSRB_RST_ENABLE &&
                pump_control == DSRB_RST_PUMP_CTL &&
                boost_control == DSRB_RST_BOOST_CTL;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("reset default wrong");

    property p_stable_no_write;
        @(posedge sys_clk) disable iff (rst)
        !wr_pc |=> $stable(pump_control);
    endproperty
    a_stable_no_write: assert property (p_stable_no_write)
        else $error("control changed without write");

    property p_level_code;
        @(posedge sys_clk) disable iff (rst)
        wr_pl |=> positive_level_code == $past(rx_byte[DSRB_LEVEL_MSB:0]);
    endproperty
    a_level_code: assert property (p_level_code)
        else $error("level code mismatch");

    property p_pin_clear;
        @(posedge sys_clk) disable iff (rst)
        pin_cycle && flt_set == 4'h0 |=> fault_status[3:0] == 4'h0;
    endproperty
    a_pin_clear: assert property (p_pin_clear)
        else $error("pin cycle did not clear faults");

    property p_otp_second;
        @(posedge sys_clk) disable iff (rst)
        otp_clear && !otp_event |=>
            !fault_status[0] && fault_status[3:1] == $past(fault_status[3:1]);
    endproperty
    a_otp_second: assert property (p_otp_second)
        else $error("second read clear wrong");

    property p_boost_enable;
        @(posedge sys_clk) disable iff (rst)
        boost_rail_on |-> rail_enable[0] && (sy.pos_pin || sy.neg_pin);
    endproperty
    a_boost_enable: assert property (p_boost_enable)
        else $error("boost enabled wrongly");

    property p_no_ack_miss;
        @(posedge sys_clk) disable iff (rst)
        state == DSRB_DEVADR && byte_done && !addr_hit && !start_det
            && !stop_det |=> state == DSRB_WAIT;
    endproperty
    a_no_ack_miss: assert property (p_no_ack_miss)
        else $error("foreign address accepted");

    property p_stop_drops;
        @(posedge sys_clk) disable iff (rst)
        stop_det && state == DSRB_WDATA |=>
            $stable(negative_level) && $stable(positive_level);
    endproperty
    a_stop_drops: assert property (p_stop_drops)
        else $error("write during stop");

    c_write: cover property (@(posedge sys_clk) disable iff (rst) wr_en);
    c_read: cover property (@(posedge sys_clk) disable iff (rst) rd_load);
    c_otp_clr: cover property (@(posedge sys_clk) disable iff (rst)
        otp_clear);
    c_pin_cyc: cover property (@(posedge sys_clk) disable iff (rst)
        pin_cycle);
endmodule

/* dsrb_pkg.sv */
// Package of register map, field positions and reset values
package dsrb_pkg;
    localparam logic [6:0] DSRB_DEV_ADDR = 7'h29;
    localparam logic [7:0] DSRB_OFS_FAULT = 8'h04;
    localparam logic [7:0] DSRB_OFS_ENABLE = 8'h05;
    localparam logic [7:0] DSRB_OFS_BOOST_LVL = 8'h06;
    localparam logic [7:0] DSRB_OFS_NEG_LVL = 8'h08;
    localparam logic [7:0] DSRB_OFS_POS_LVL = 8'h09;
    localparam logic [7:0] DSRB_OFS_BOOST_CTL = 8'h0d;
    localparam logic [7:0] DSRB_OFS_PUMP_CTL = 8'h0f;
    localparam logic [7:0] DSRB_RST_FAULT = 8'h00;
    localparam logic [7:0] DSRB_RST_ENABLE = 8'h07;
    localparam logic [7:0] DSRB_RST_LEVEL = 8'h00;
    localparam logic [7:0] DSRB_RST_BOOST_CTL = 8'h34;
    localparam logic [7:0] DSRB_RST_PUMP_CTL = 8'hda;
    localparam int DSRB_EN_BOOST_BIT = 0;
    localparam int DSRB_EN_NEG_BIT = 1;
    localparam int DSRB_EN_POS_BIT = 2;
    localparam int DSRB_EN_PULLDN_DIS_BIT = 6;
    localparam int DSRB_FLT_OTP_BIT = 0;
    localparam int DSRB_LEVEL_MSB = 4;
    localparam int DSRB_BC_SLEW_LSB = 4;
    localparam int DSRB_BC_PFM_DIS_BIT = 3;
    localparam int DSRB_PC_PFM_DIS_BIT = 5;
    localparam int DSRB_PC_MIN_PULSE_BIT = 4;
    localparam int DSRB_PC_PEAK_LSB = 2;
    localparam int DSRB_PC_PULSE_LSB = 0;
    localparam logic [7:0] DSRB_EN_WMASK = 8'h7f;
    localparam logic [7:0] DSRB_BC_RSV = 8'h00;
    localparam logic [7:0] DSRB_PC_RSV = 8'hc0;
endpackage

/* dsrb_sync_if.sv */
// Interface carrying synchronised bus and pin levels
interface dsrb_sync_if;
    logic scl;
    logic sda;
    logic pos_pin;
    logic neg_pin;
    modport src (output scl, sda, pos_pin, neg_pin);
    modport dst (input scl, sda, pos_pin, neg_pin);
endinterface

/* dsrb_sync.sv */
// Two-stage synchroniser for serial pins and enable pins
module dsrb_sync
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic pos_in,
    input wire logic neg_in,
    dsrb_sync_if.src so
);
    logic [3:0] stage1;
    logic [3:0] stage2;
    wire [3:0] raw = {neg_in, pos_in, sda_in, scl_in};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            stage1 <= 4'hf;
            stage2 <= 4'hf;
        end
        else
        begin
            stage1 <= raw;
            stage2 <= stage1;
        end
    end

    assign so.scl = stage2[0];
    assign so.sda = stage2[1];
    assign so.pos_pin = stage2[2];
    assign so.neg_pin = stage2[3];
endmodule

/* dsrb_host_model.sv */
// Serial bus host model for the register bank bench
module dsrb_host_model
    import dsrb_pkg::*;
(
    input wire logic sys_clk,
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] acks;

    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
        acks = 4'h0;
    end

    // ------------------------------------------------------------
    // Line phases, 80 ns each, so the serial clock runs at 160 ns
    // ------------------------------------------------------------
    task automatic step(input logic c, input logic d);
        scl <= c;
        repeat (2) @(posedge sys_clk);
        sda_drv <= d;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic start();
        step(1'b0, 1'b1);
        step(1'b1, 1'b0);
    endtask

    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b1);
    endtask

    // Sample at end of high phase
    task automatic bit_io(input logic b, output logic s);
        step(1'b0, b);
        step(1'b1, b);
        s = sda_line;
    endtask

    // ------------------------------------------------------------
    // Bytes and transfers
    // ------------------------------------------------------------
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask

    task automatic get(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, s);
    endtask

    task automatic write(input logic [6:0] dev, input logic [7:0] a,
                         input logic [7:0] d, input int nbits);
        logic s;
        acks = 4'h0;
        start();
        put({dev, 1'b0}, acks[0]);
        put(a, acks[1]);
        if (nbits == 8)
            put(d, acks[2]);
        else
            for (int i = 7; i > 7 - nbits; i--)
                bit_io(d[i], s);
        stop();
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        acks = 4'h0;
        start();
        put({DSRB_DEV_ADDR, 1'b0}, acks[0]);
        put(a, acks[1]);
        start();
        put({DSRB_DEV_ADDR, 1'b1}, acks[2]);
        get(1'b1, d);
        stop();
    endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the display supply register bank
module tb_top
    import dsrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic scl;
    logic sda_drv;
    logic pos_pin = 1'b1;
    logic neg_pin = 1'b1;
    logic otp_event = 1'b0;
    logic [2:0] uv_flag = 3'h0;
    wire sda_out;
    wire sda_oe_n;
    wire sda_line;
    wire [3:0] rails;
    wire [4:0] lvl_b;
    wire [4:0] lvl_n;
    wire [4:0] lvl_p;
    wire [5:0] bctl;
    wire [5:0] pctl;
    int miscompares = 0;
    int n_tests = 0;
    int mdl [16];
    int unsigned seed = 25080;
    const logic [7:0] offs [7] = '{DSRB_OFS_FAULT, DSRB_OFS_ENABLE,
        DSRB_OFS_BOOST_LVL, DSRB_OFS_NEG_LVL, DSRB_OFS_POS_LVL,
        DSRB_OFS_BOOST_CTL, DSRB_OFS_PUMP_CTL};

    // Open-drain data line with pull-up
    assign sda_line = sda_drv & (sda_oe_n | sda_out);
    always #10 sys_clk = ~sys_clk;

    dsrb_top i_dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .positive_rail_enable_pin(pos_pin),
        .negative_rail_enable_pin(neg_pin), .otp_event(otp_event),
        .undervoltage_flag(uv_flag), .boost_rail_on(rails[3]),
        .negative_pump_rail_on(rails[2]), .positive_ldo_rail_on(rails[1]),
        .positive_pulldown_off(rails[0]), .boost_level_code(lvl_b),
        .negative_level_code(lvl_n), .positive_level_code(lvl_p),
        .switch_node_slew(bctl[5:4]),
        .boost_light_load_pulse_mode_off(bctl[3]),
        .boost_freq_sel(bctl[2:0]), .pump_light_load_pulse_mode_off(pctl[5]),
        .pump_min_pulse_short(pctl[4]), .pump_peak_current_sel(pctl[3:2]),
        .pump_pulse_len_sel(pctl[1:0]));

    dsrb_host_model i_host (.sys_clk(sys_clk), .scl(scl),
        .sda_drv(sda_drv), .sda_line(sda_line));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic complete_run();
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic mdl_reset();
        mdl = '{default: 0};
        mdl[5] = DSRB_RST_ENABLE;
        mdl[13] = DSRB_RST_BOOST_CTL;
        mdl[15] = DSRB_RST_PUMP_CTL;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.write(DSRB_DEV_ADDR, a, d, 8);
        chk("write ack", 8'h07, {5'h0, i_host.acks[2:0]});
        mdl[a] = d;
    endtask

    task automatic check_regs();
        logic [7:0] d;
        foreach (offs[i])
        begin
            i_host.read(offs[i], d);
            chk("register", 8'(mdl[offs[i]]), d);
            chk("read ack", 8'h07, {5'h0, i_host.acks[2:0]});
        end
    endtask

    task automatic check_outs();
        logic [7:0] en;
        en = 8'(mdl[5]);
        repeat (4) @(posedge sys_clk);
        chk("rails", {4'h0, en[0] & (pos_pin | neg_pin), en[1] & neg_pin,
            en[2] & pos_pin, en[6]}, {4'h0, rails});
        chk("boost level", 8'(mdl[6] % 32), {3'h0, lvl_b});
        chk("negative level", 8'(mdl[8] % 32), {3'h0, lvl_n});
        chk("positive level", 8'(mdl[9] % 32), {3'h0, lvl_p});
        chk("boost control", 8'(mdl[13] % 64), {2'h0, bctl});
        chk("pump control", 8'(mdl[15] % 64), {2'h0, pctl});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] d;
        logic [31:0] r;
        mdl_reset();
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        check_regs();
        check_outs();
        for (int k = 0; k < 4; k++)
        begin
            r = rnd();
            // legal codes, reserved values, no soft-start
            wr(DSRB_OFS_ENABLE, r[7:0] & 8'h7f);
            wr(DSRB_OFS_BOOST_LVL, {r[15:13], 5'(k + 1)});
            wr(DSRB_OFS_NEG_LVL, {r[18:16], 5'(k % 3)});
            wr(DSRB_OFS_POS_LVL, {r[21:19], 5'(2 - k % 3)});
            wr(DSRB_OFS_BOOST_CTL, {2'b00, 2'(k), r[22], r[25:23]});
            wr(DSRB_OFS_PUMP_CTL, {2'b11, r[27:26], 2'(k), 2'(3 - k)});
            pos_pin <= r[28];
            neg_pin <= r[29];
            check_regs();
            check_outs();
        end
        i_host.write(7'h2a, DSRB_OFS_POS_LVL, 8'h01, 8);
        chk("foreign ack", 8'h00, {7'h0, i_host.acks[0]});
        i_host.write(DSRB_DEV_ADDR, DSRB_OFS_NEG_LVL, 8'h1f, 6);
        i_host.write(DSRB_DEV_ADDR, DSRB_OFS_POS_LVL, 8'h55, 3);
        i_host.read(8'h07, d);
        chk("unlisted", 8'h00, d);
        check_regs();
        r = rnd();
        uv_flag <= r[2:0] | 3'h2;
        otp_event <= 1'b1;
        @(posedge sys_clk);
        uv_flag <= 3'h0;
        otp_event <= 1'b0;
        mdl[4] = {4'h0, r[2:0] | 3'h2, 1'b1};
        i_host.read(DSRB_OFS_FAULT, d);
        chk("fault first", 8'(mdl[4]), d);
        i_host.read(DSRB_OFS_FAULT, d);
        chk("fault second", 8'(mdl[4]), d);
        mdl[4] = mdl[4] & 14;
        i_host.read(DSRB_OFS_FAULT, d);
        chk("fault third", 8'(mdl[4]), d);
        pos_pin <= 1'b0;
        neg_pin <= 1'b0;
        repeat (6) @(posedge sys_clk);
        pos_pin <= 1'b1;
        neg_pin <= 1'b1;
        repeat (6) @(posedge sys_clk);
        mdl[4] = 0;
        i_host.read(DSRB_OFS_FAULT, d);
        chk("fault cleared", 8'h00, d);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        mdl_reset();
        repeat (6) @(posedge sys_clk);
        check_regs();
        check_outs();
        complete_run();
    end

    // Hang guard, about two and a half times the expected run
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        miscompares++;
        complete_run();
    end
endmodule
